// *** logic/fsc_pkg.sv ***
// package: register map, flash command codes and timing for the flash host controller
package fsc_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned WAKE_READ_NS = 1000;
  localparam int unsigned WAKE_WRITE_NS = 1000;
  localparam int unsigned WAKE_READ_CYC = ((WAKE_READ_NS * 25) + 999) / 1000;
  localparam int unsigned WAKE_WRITE_CYC = ((WAKE_WRITE_NS * 25) + 999) / 1000;
  localparam int unsigned STROBE_NS = 100;
  localparam int unsigned STROBE_CYC = ((STROBE_NS * 25) + 999) / 1000;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ = 8'h14;
  localparam logic [7:0] OFS_MASK = 8'h18;
  localparam logic [7:0] OFS_RDATA = 8'h1c;
  localparam int unsigned CTRL_PWR = 0;
  localparam int unsigned CMD_GO = 0;
  localparam int unsigned CMD_WR = 1;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_READY = 1;
  localparam int unsigned IRQ_ABORT = 2;
  localparam int unsigned IRQ_W = 3;
  localparam logic [7:0] FL_READ_ARRAY = 8'hff;
  localparam logic [7:0] FL_READ_STATUS = 8'h70;
  localparam logic [7:0] FL_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] FL_CONFIRM = 8'hd0;
  localparam int unsigned SR_SUPPLY_ERR = 3;
  localparam int unsigned SR_WRITE_ERR = 4;
  localparam int unsigned SR_ERASE_ERR = 5;
  localparam int unsigned SR_READY = 7;
endpackage : fsc_pkg

// *** logic/fsc_sync.sv ***
// two-flop synchroniser for pins arriving from the flash
`timescale 1ns/1ns
module fsc_sync #(
  parameter int W = 1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : fsc_sync

// *** logic/fsc_host.sv ***
// flash host controller: ahb-lite registers to parallel flash pins
// What this block does, and what it leaves to software
// - host writes read array before array reads (not enforced here; the block only reports array_mode in status bit 4)
// - writes need strobe and select both low
// - host reissues aborted sequences completely (left to software; the block only raises the IRQ_ABORT flag)
// - host waits wake delays after reset release
// - read array command code is ff
//
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ns
module fsc_host #(
  parameter int AW = 21
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  output logic [AW-1:0] flash_addr,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe_n,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic reset_powerdown_n,
  input wire logic ready_status_output
);
  import fsc_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_SETUP, ST_STROBE, ST_HOLD} fsc_state_t;

  fsc_state_t state;
  logic pwr_on;
  logic [15:0] cmd_data;
  logic [AW-1:0] cmd_addr;
  logic cmd_wr;
  logic [15:0] rdata;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [15:0] wake_cnt;
  logic [7:0] step_cnt;
  logic busy_flag;
  logic ready_s;
  logic ready_n_s;
  logic ready_q;
  logic array_mode;
  logic [15:0] dq_s;
  logic a_valid;
  logic a_write;
  logic [7:0] a_off;
  logic go_pulse;
  logic ev_done;
  logic ev_abort;
  logic wake_ok;

  // ready pin is open drain with pull-up, watched at all times
  // synchronised inverted so that it idles high out of reset and no false rising edge follows
  fsc_sync #(.W(17)) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({!ready_status_output, flash_dq_in}),
    .q({ready_n_s, dq_s})
  );

  assign ready_s = !ready_n_s;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_valid <= 1'b0;
      a_write <= 1'b0;
      a_off <= 8'h00;
    end else if (hready) begin
      a_valid <= hsel && htrans[1] && hsize == 3'b010;
      a_write <= hwrite;
      a_off <= haddr[7:0];
    end
  end

  assign go_pulse = a_valid && a_write && a_off == OFS_CMD && hwdata[CMD_GO] && state == ST_IDLE && wake_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_on <= 1'b0;
      cmd_data <= 16'h0000;
      cmd_addr <= '0;
      irq_mask <= '0;
    end else if (a_valid && a_write) begin
      case (a_off)
        OFS_CTRL: pwr_on <= hwdata[CTRL_PWR];
        OFS_ADDR: cmd_addr <= hwdata[AW-1:0];
        OFS_DATA: cmd_data <= hwdata[15:0];
        OFS_MASK: irq_mask <= hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  always_comb begin
    hrdata = 32'h0000_0000;
    case (a_off)
      OFS_CTRL: hrdata[CTRL_PWR] = pwr_on;
      OFS_ADDR: hrdata[AW-1:0] = cmd_addr;
      OFS_DATA: hrdata[15:0] = cmd_data;
      OFS_STATUS: hrdata[4:0] = {array_mode, wake_ok, busy_flag, state != ST_IDLE, ready_s};
      OFS_IRQ: hrdata[IRQ_W-1:0] = irq_stat;
      OFS_MASK: hrdata[IRQ_W-1:0] = irq_mask;
      OFS_RDATA: hrdata[15:0] = rdata;
      default: hrdata = 32'h0000_0000;
    endcase
  end

  // reset pin follows the power control bit; lowering it clears device status
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_powerdown_n <= 1'b0;
      wake_cnt <= 16'h0000;
    end else begin
      reset_powerdown_n <= pwr_on;
      if (!pwr_on) begin
        wake_cnt <= 16'h0000;
      end else if (wake_cnt < 16'(WAKE_WRITE_CYC > WAKE_READ_CYC ? WAKE_WRITE_CYC : WAKE_READ_CYC)) begin
        wake_cnt <= wake_cnt + 16'h0001;
      end
    end
  end

  assign wake_ok = reset_powerdown_n && wake_cnt >= 16'(WAKE_WRITE_CYC > WAKE_READ_CYC ? WAKE_WRITE_CYC : WAKE_READ_CYC);

  // hint for software: array reads are safe after reset, after power-down, or once the read array code was strobed
  // program data that happens to equal that code also sets it
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      array_mode <= 1'b1;
    end else if (!pwr_on) begin
      array_mode <= 1'b1;
    end else if (state == ST_SETUP && cmd_wr) begin
      array_mode <= flash_dq_out[7:0] == FL_READ_ARRAY;
    end
  end

  // one bus cycle per command: write or read, ce and strobe both low only while strobing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      step_cnt <= 8'h00;
      cmd_wr <= 1'b0;
      flash_addr <= '0;
      flash_dq_out <= 16'h0000;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
      rdata <= 16'h0000;
    end else if (!pwr_on) begin
      state <= ST_IDLE;
      flash_dq_oe_n <= 1'b1;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go_pulse) begin
            cmd_wr <= hwdata[CMD_WR];
            flash_addr <= cmd_addr;
            flash_dq_out <= cmd_data;
            state <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          flash_ce_n <= 1'b0;
          flash_dq_oe_n <= !cmd_wr;
          flash_we_n <= !cmd_wr;
          flash_oe_n <= cmd_wr;
          step_cnt <= 8'(STROBE_CYC);
          state <= ST_STROBE;
        end
        ST_STROBE: begin
          if (step_cnt > 8'h01) begin
            step_cnt <= step_cnt - 8'h01;
          end else begin
            flash_we_n <= 1'b1;
            flash_oe_n <= 1'b1;
            state <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (!cmd_wr) begin
            rdata <= dq_s;
          end
          flash_ce_n <= 1'b1;
          flash_dq_oe_n <= 1'b1;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // busy tracked from the ready pin, which may float high in suspend and power-down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
      busy_flag <= 1'b0;
    end else begin
      ready_q <= ready_s;
      if (!pwr_on) begin
        busy_flag <= 1'b0;
      end else if (!ready_s) begin
        busy_flag <= 1'b1;
      end else begin
        busy_flag <= 1'b0;
      end
    end
  end

  assign ev_done = state == ST_HOLD;
  assign ev_abort = busy_flag && !pwr_on && reset_powerdown_n;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat <= '0;
    end else begin
      for (int i = 0; i < IRQ_W; i++) begin
        if ((i == IRQ_DONE && ev_done) || (i == IRQ_READY && ready_s && !ready_q) ||
            (i == IRQ_ABORT && ev_abort)) begin
          irq_stat[i] <= 1'b1;
        end else if (a_valid && a_write && a_off == OFS_IRQ && hwdata[i]) begin
          irq_stat[i] <= 1'b0;
        end
      end
    end
  end

  assign irq = |(irq_stat & irq_mask);

endmodule : fsc_host

// *** verif/fsc_properties.sv ***
// checker: flash pin timing and bus response properties of the host controller
`timescale 1ns/1ns
module fsc_props
  import fsc_pkg::*;
#(
  parameter int AW = 21
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [15:0] flash_dq_out,
  input wire logic flash_dq_oe_n,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n,
  input wire logic reset_powerdown_n
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_pulse(logic x);
    !x [*3] ##1 x;
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready or not okay");
  a_we_width: assert property ($fell(flash_we_n) |-> s_pulse(flash_we_n)) else $error("write strobe width");
  a_oe_width: assert property ($fell(flash_oe_n) |-> s_pulse(flash_oe_n)) else $error("read strobe width");
  a_we_selected: assert property (!flash_we_n |-> !flash_ce_n) else $error("write strobe without select");
  a_ce_holds: assert property ($rose(flash_we_n) |-> !flash_ce_n ##1 flash_ce_n) else $error("select hold");
  a_no_fight: assert property (!flash_dq_oe_n |-> flash_oe_n) else $error("data bus driven both ways");
  a_data_steady: assert property (!flash_we_n && !$past(flash_we_n) |-> $stable(flash_dq_out) && $stable(flash_addr))
    else $error("write data moved under strobe");
  a_pd_quiet: assert property (!reset_powerdown_n |-> flash_we_n && flash_ce_n && flash_dq_oe_n)
    else $error("strobe active in power-down");
  a_wake_write: assert property ($rose(reset_powerdown_n) |-> flash_we_n [*8]) else $error("write too soon");
endmodule : fsc_props

// *** verif/fsc_flash_model.sv ***
// flash device model: command latch, status bits, ready pin, data bus
`timescale 1ns/1ns
module fsc_flash_model (
  input wire logic hclk,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rp_n,
  input wire logic vpp_ok,
  input wire logic [20:0] addr,
  input wire logic [15:0] din,
  output logic [15:0] dout,
  output wire logic ready
);
  logic [7:0] cmd = 8'hff;
  logic [7:0] st = 8'h00;
  logic [15:0] last = 16'h0000;
  logic we_q = 1'b1;
  int busy = 0;
  assign ready = (busy > 0) ? 1'b0 : 1'b1;
  assign dout = (!ce_n && !oe_n && rp_n) ? ((cmd == 8'hff) ? addr[15:0] ^ 16'h5a5a : {8'h00, busy == 0, st[6:0]})
    : ~last;
  always @(posedge hclk) if (!ce_n && !oe_n) last <= dout;
  always @(posedge hclk or negedge rp_n) begin
    if (!rp_n) begin
      busy <= 0;
      st <= 8'h00;
      cmd <= 8'hff;
      we_q <= 1'b1;
    end else begin
      we_q <= we_n;
      if (busy > 0) busy <= busy - 1;
      if (!we_q && we_n && !ce_n) begin
        if ((cmd == 8'h20 && din[7:0] == 8'hd0) || cmd == 8'h40) begin
          busy <= 40;
          cmd <= 8'h70;
          if (!vpp_ok) st <= st | {2'b00, cmd == 8'h20, cmd == 8'h40, 1'b1, 3'b000};
        end else begin
          cmd <= din[7:0];
          if (din[7:0] == 8'h50) st <= 8'h00;
        end
      end
    end
  end
endmodule : fsc_flash_model

// *** verif/tb_top.sv ***
// testbench: drives the flash host controller over ahb-lite against the flash model
`timescale 1ns/1ns
module tb_top;
  import fsc_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 1, hwrite = 0, vpp_ok = 1;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
  logic [20:0] flash_addr;
  logic [15:0] flash_dq_out, dout, dq;
  logic hreadyout, hresp, irq, flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n, reset_powerdown_n;
  wire logic ready_status_output;
  int errors = 0, checks_done = 0;
  logic [7:0] setup [2] = '{8'h20, 8'h40};
  logic [7:0] second [2] = '{8'hd0, 8'h12};
  logic [31:0] stexp [2] = '{32'ha8, 32'h98};
  always #20 hclk = ~hclk;
  assign dq = !flash_dq_oe_n ? flash_dq_out : dout;
  fsc_host i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'b010), .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .irq, .flash_addr, .flash_dq_in(dq), .flash_dq_out, .flash_dq_oe_n, .flash_ce_n,
    .flash_oe_n, .flash_we_n, .reset_powerdown_n, .ready_status_output);
  fsc_flash_model i_flash (.hclk, .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .rp_n(reset_powerdown_n),
    .vpp_ok, .addr(flash_addr), .din(dq), .dout, .ready(ready_status_output));
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      bus(0, a, 0, r);
      n++;
    end while (r[b] !== 1'b1 && n < 100);
    if (r[b] !== 1'b1) chk("poll", 0, 1);
  endtask : poll
  task automatic fl(input logic w, input logic [31:0] a, input logic [31:0] d);
    bus(1, OFS_ADDR, a, r);
    bus(1, OFS_DATA, d, r);
    bus(1, OFS_CMD, {30'h0, w, 1'b1}, r);
    poll(OFS_IRQ, IRQ_DONE);
    bus(1, OFS_IRQ, 32'h1, r);
  endtask : fl
  task close_out;
    $display("errors %0d checks %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : close_out
  initial begin
    #800000;
    errors++;
    close_out;
  end
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    chk("pd_at_reset", reset_powerdown_n, 0);
    bus(1, OFS_CTRL, 32'h1, r);
    bus(0, OFS_STATUS, 0, r);
    chk("wake_early", r[3], 0);
    repeat (30) @(posedge hclk);
    bus(0, OFS_STATUS, 0, r);
    chk("status_idle", r, 32'h19);
    vpp_ok <= 0;
    for (int i = 0; i < 2; i++) begin
      fl(1, 0, FL_CLEAR_STATUS);
      fl(1, 0, setup[i]);
      fl(1, 4, second[i]);
      bus(0, OFS_STATUS, 0, r);
      chk("ready_busy", r[0], 0);
      chk("array_left", r[4], 0);
      poll(OFS_STATUS, 0);
      fl(1, 0, FL_READ_STATUS);
      fl(0, 0, 0);
      bus(0, OFS_RDATA, 0, r);
      chk("supply_error", r, stexp[i]);
    end
    chk("irq_masked", irq, 0);
    bus(1, OFS_MASK, 32'h2, r);
    @(posedge hclk);
    chk("irq_raised", irq, 1);
    bus(1, OFS_IRQ, 32'h2, r);
    @(posedge hclk);
    chk("irq_cleared", irq, 0);
    vpp_ok <= 1;
    fl(1, 0, FL_READ_ARRAY);
    bus(0, OFS_STATUS, 0, r);
    chk("array_mode", r[4], 1);
    fl(0, 5, 0);
    bus(0, OFS_RDATA, 0, r);
    chk("array_read", r, 32'h5 ^ 32'h5a5a);
    fl(1, 0, setup[0]);
    fl(1, 0, second[0]);
    bus(1, OFS_CTRL, 32'h0, r);
    bus(0, OFS_IRQ, 0, r);
    chk("abort_flag", r[IRQ_ABORT], 1);
    bus(1, OFS_CTRL, 32'h1, r);
    repeat (30) @(posedge hclk);
    fl(0, 5, 0);
    bus(0, OFS_RDATA, 0, r);
    chk("latch_after_pd", r, 32'h5 ^ 32'h5a5a);
    fl(1, 0, FL_READ_STATUS);
    fl(0, 0, 0);
    bus(0, OFS_RDATA, 0, r);
    chk("status_cleared", r, 32'h80);
    bus(0, 8'h40, 0, r);
    chk("unmapped", r, 0);
    close_out;
  end
endmodule : tb_top

bind fsc_host fsc_props #(.AW(AW)) i_props (.hclk, .hresetn, .hreadyout, .hresp, .flash_addr, .flash_dq_out,
  .flash_dq_oe_n, .flash_ce_n, .flash_oe_n, .flash_we_n, .reset_powerdown_n);
